// [verilog/sample_buffer_defines.vh]
// Constants shared by the sample buffer design files
`ifndef SAMPLE_BUFFER_DEFINES_VH
`define SAMPLE_BUFFER_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_SAMPLE_THRESHOLD 8'h3a
`define ADDR_BUFFER_CONTROL 8'h3b
`define ADDR_BYTE_LEVEL 8'h3c
`define ADDR_TRIGGER_STATUS 8'h3d
`define ADDR_FLUSH 8'h3e
`define ADDR_OUTPUT_PORT 8'h3f

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_ENABLE_BIT 7
`define CTRL_RES_BIT 6
`define CTRL_FULL_IE_BIT 5
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
`define THRESH_RESET 8'h00
`define CTRL_RESET 8'h00
`define CTRL_WRITE_MASK 8'he3
`define THRESH_WRITE_MASK 8'h7f

// ****************************************************************
// Modes and sizes
// ****************************************************************
`define MODE_FIFO 2'h0
`define MODE_STREAM 2'h1
`define MODE_TRIGGER 2'h2
`define MODE_LIFO 2'h3
`define BUF_BYTES 9'h102
`define BYTES_HI 9'h6
`define BYTES_LO 9'h3
`define BYTE_ZERO 8'h00
`define PTR_ZERO 9'h000
`define PTR_ONE 9'h001

`endif

// [verilog/edge_sync.v]
// Three-stage synchroniser with rising edge and agreed level
`timescale 1ns/1ns
`default_nettype none

module edge_sync (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Asynchronous input
    input wire async_in,
    // Synchronised outputs
    output wire level_out,
    output wire rise_out
);

    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg level_reg;
    reg rise_reg;

    // Change counts once stages two and three agree
    always @(posedge mclk) begin
        if (reset) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            rise_reg <= 1'b0;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
                rise_reg <= s3_reg & ~level_reg;
            end
        end
    end

    assign level_out = level_reg;
    assign rise_out = rise_reg;

endmodule // edge_sync

`default_nettype wire

// [verilog/accel_sample_buffer.v]
// Sample buffer for a three-axis motion sensor, register mapped
//
// Overview of operation
// - Outside trigger mode, threshold sets samples needed for watermark.
// - In trigger mode, threshold sets pre-trigger samples kept.
// - Capacity is 43 samples at 16 bits, 86 at 8 bits.
// - Resolution bit clear gives 3-byte samples, set gives 6-byte samples.
// - Full interrupt appears only while its enable bit is set.
// - FIFO mode stops accepting samples when full until space frees.
// - Stream mode overwrites the oldest sample when full.
// - Trigger mode keeps pre-trigger window, then fills until full.
// - LIFO mode overwrites oldest when full, reads newest first.
// - Level register reports low 8 bits of stored byte count, so 256 bytes also reads zero.
// - Trigger status shows in bit 7, other bits read zero.
// - Any write to flush register empties buffer; status clears unless a trigger event lands that cycle.
// - Sample writing is suspended while the host reads output.
// - FIFO readout starts at oldest byte of oldest sample.
// - LIFO readout starts at newest byte of newest sample.
// - Outside trigger mode, watermark holds while sample count is at or above a nonzero threshold.
// - Trigger fires on engine interrupt or high trigger pin once sample count reaches a nonzero threshold.
`timescale 1ns/1ns
`default_nettype none
`include "sample_buffer_defines.vh"

module accel_sample_buffer (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Read operation in progress on the serial bus
    input wire read_active,
    // Sample source, one pulse per output data rate period
    input wire sample_valid,
    input wire [47:0] sample_data,
    // Trigger sources
    input wire engine_interrupt,
    input wire external_trigger_pin,
    // Status outputs
    output reg watermark_irq,
    output reg full_irq
);

    // ****************************************************************
    // Registers and storage
    // ****************************************************************
    reg [7:0] buffer_sample_threshold_reg;
    reg [7:0] buffer_control_reg;
    reg [7:0] mem_reg [0:257];
    reg [8:0] wr_ptr_reg;
    reg [8:0] rd_ptr_reg;
    reg [8:0] level_reg;
    reg trigger_seen_flag_reg;
    reg capture_busy_reg;
    reg [2:0] cap_idx_reg;
    reg [47:0] cap_data_reg;
    wire external_trigger_pin_level;

    wire buffer_enable = buffer_control_reg[`CTRL_ENABLE_BIT];
    wire sample_resolution_select = buffer_control_reg[`CTRL_RES_BIT];
    wire full_interrupt_enable = buffer_control_reg[`CTRL_FULL_IE_BIT];
    wire [1:0] buffer_operating_mode =
        buffer_control_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire [6:0] watermark_sample_count = buffer_sample_threshold_reg[6:0];

    // Trigger pin comes from outside the clock domain
    edge_sync u_external_trigger_pin_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in(external_trigger_pin),
        .level_out(external_trigger_pin_level),
        .rise_out()
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Bytes per stored sample for a given resolution
    function [8:0] sample_bytes;
        input res;
        begin
            sample_bytes = res ? `BYTES_HI : `BYTES_LO;
        end
    endfunction

    // Wrap a byte pointer around the storage
    function [8:0] wrap_add;
        input [8:0] p;
        input [8:0] n;
        reg [9:0] s;
        begin
            s = {1'b0, p} + {1'b0, n};
            if (s >= {1'b0, `BUF_BYTES}) begin
                s = s - {1'b0, `BUF_BYTES};
            end
            wrap_add = s[8:0];
        end
    endfunction

    // Step a pointer back by one byte
    function [8:0] wrap_dec;
        input [8:0] p;
        begin
            wrap_dec = (p == `PTR_ZERO) ? (`BUF_BYTES - `PTR_ONE) : (p - `PTR_ONE);
        end
    endfunction

    wire [8:0] smp_bytes = sample_bytes(sample_resolution_select);
    // 258 bytes hold 43 six-byte or 86 three-byte samples
    wire buf_full = (level_reg == `BUF_BYTES);
    wire [15:0] thresh_bytes = watermark_sample_count * smp_bytes;
    wire at_threshold = (thresh_bytes[8:0] != `PTR_ZERO) &&
        ({7'h00, level_reg} >= thresh_bytes);
    wire external_trigger_pin_event = engine_interrupt | external_trigger_pin_level;
    wire is_mode_trigger = (buffer_operating_mode == `MODE_TRIGGER);
    wire is_mode_lifo = (buffer_operating_mode == `MODE_LIFO);
    wire flush_wr = reg_wr && (reg_addr == `ADDR_FLUSH);
    wire out_rd = reg_rd && (reg_addr == `ADDR_OUTPUT_PORT);

    // Decide per sample whether to overwrite the oldest entry
    wire overwrite_mode = (buffer_operating_mode == `MODE_STREAM) || is_mode_lifo ||
        (is_mode_trigger && !trigger_seen_flag_reg);
    // Trigger pre-window: drop oldest once threshold reached before trigger
    wire drop_for_window = is_mode_trigger && !trigger_seen_flag_reg && at_threshold;
    wire sample_start = sample_valid && buffer_enable && !read_active &&
        !capture_busy_reg;
    // FIFO and post-trigger refuse new data while full
    wire room_ok = !buf_full || overwrite_mode;

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Control fields steer the buffer; reserved bits stay zero
    always @(posedge mclk) begin
        if (reset) begin
            buffer_sample_threshold_reg <= `THRESH_RESET;
            buffer_control_reg <= `CTRL_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_SAMPLE_THRESHOLD) begin
                buffer_sample_threshold_reg <= reg_wdata & `THRESH_WRITE_MASK;
            end
            if (reg_addr == `ADDR_BUFFER_CONTROL) begin
                buffer_control_reg <= reg_wdata & `CTRL_WRITE_MASK;
            end
        end
    end

    // ****************************************************************
    // Trigger status
    // ****************************************************************
    // Event wins over a flush arriving in the same cycle
    always @(posedge mclk) begin
        if (reset) begin
            trigger_seen_flag_reg <= 1'b0;
        end else if (is_mode_trigger && external_trigger_pin_event && at_threshold) begin
            trigger_seen_flag_reg <= 1'b1;
        end else if (flush_wr) begin
            trigger_seen_flag_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Storage, pointers and level
    // ****************************************************************
    // Sample bytes are written one per cycle; an output port read or flush aborts
    // the pending capture so a partial sample never shows in the level
    always @(posedge mclk) begin
        if (reset) begin
            wr_ptr_reg <= `PTR_ZERO;
            rd_ptr_reg <= `PTR_ZERO;
            level_reg <= `PTR_ZERO;
            capture_busy_reg <= 1'b0;
            cap_idx_reg <= 3'h0;
            cap_data_reg <= 48'h0;
        end else if (flush_wr) begin
            wr_ptr_reg <= `PTR_ZERO;
            rd_ptr_reg <= `PTR_ZERO;
            level_reg <= `PTR_ZERO;
            capture_busy_reg <= 1'b0;
        end else if (out_rd) begin
            // One byte leaves per read
            if (level_reg != `PTR_ZERO) begin
                level_reg <= level_reg - `PTR_ONE;
                if (is_mode_lifo) begin
                    wr_ptr_reg <= wrap_dec(wr_ptr_reg);
                end else begin
                    rd_ptr_reg <= wrap_add(rd_ptr_reg, `PTR_ONE);
                end
            end
            capture_busy_reg <= 1'b0;
        end else if (capture_busy_reg) begin
            // Sequential byte fill, X first: low X byte at 16 bits, high X byte at 8 bits
            mem_reg[wr_ptr_reg] <= cap_data_reg[7:0];
            cap_data_reg <= {8'h00, cap_data_reg[47:8]};
            wr_ptr_reg <= wrap_add(wr_ptr_reg, `PTR_ONE);
            if ({6'h00, cap_idx_reg} == smp_bytes - `PTR_ONE) begin
                capture_busy_reg <= 1'b0;
                level_reg <= level_reg + smp_bytes;
            end
            cap_idx_reg <= cap_idx_reg + 3'h1;
        end else if (sample_start && room_ok) begin
            capture_busy_reg <= 1'b1;
            cap_idx_reg <= 3'h0;
            cap_data_reg <= sample_resolution_select ? sample_data :
                {24'h0, sample_data[47:40], sample_data[31:24], sample_data[15:8]};
            // Make room by discarding the oldest sample first
            if (buf_full || drop_for_window) begin
                rd_ptr_reg <= wrap_add(rd_ptr_reg, smp_bytes);
                level_reg <= level_reg - smp_bytes;
            end
        end
    end

    // ****************************************************************
    // Read data and status outputs
    // ****************************************************************
    // Read data is registered on the read strobe
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= `BYTE_ZERO;
            watermark_irq <= 1'b0;
            full_irq <= 1'b0;
        end else begin
            // Watermark follows the level, so reads or flush drop it
            watermark_irq <= !is_mode_trigger && at_threshold && !flush_wr;
            full_irq <= full_interrupt_enable && buf_full && !flush_wr;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_SAMPLE_THRESHOLD: reg_rdata <= buffer_sample_threshold_reg;
                    `ADDR_BUFFER_CONTROL: reg_rdata <= buffer_control_reg;
                    `ADDR_BYTE_LEVEL: reg_rdata <= level_reg[7:0];
                    `ADDR_TRIGGER_STATUS: reg_rdata <= {trigger_seen_flag_reg, 7'h00};
                    `ADDR_OUTPUT_PORT: begin
                        if (level_reg == `PTR_ZERO) begin
                            reg_rdata <= `BYTE_ZERO;
                        end else if (is_mode_lifo) begin
                            reg_rdata <= mem_reg[wrap_dec(wr_ptr_reg)];
                        end else begin
                            reg_rdata <= mem_reg[rd_ptr_reg];
                        end
                    end
                    default: reg_rdata <= `BYTE_ZERO;
                endcase
            end
        end
    end

endmodule // accel_sample_buffer

`default_nettype wire

// [verif/accel_sample_buffer_sva.sv]
// Checker on the register port and status levels of the sample buffer
`timescale 1ns/1ns
`default_nettype none

module accel_sample_buffer_sva (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Status outputs
    input wire watermark_irq,
    input wire full_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Host accesses that may legally lower a level
    wire host_ev = reg_wr || (reg_rd && reg_addr == 8'h3f);

    property p_stat;
        reg_rd && reg_addr == 8'h3d |=> reg_rdata[6:0] == 7'h00;
    endproperty
    a_stat: assert property (p_stat) else $error("status low bits set");
    property p_thr;
        reg_rd && reg_addr == 8'h3a |=> !reg_rdata[7];
    endproperty
    a_thr: assert property (p_thr) else $error("threshold bit 7 set");
    property p_ctrl;
        reg_wr && reg_addr == 8'h3b ##1 reg_rd && reg_addr == 8'h3b
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'he3);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control readback");
    property p_flush;
        reg_wr && reg_addr == 8'h3e |=> ##1 !full_irq && !watermark_irq;
    endproperty
    a_flush: assert property (p_flush) else $error("levels after flush");
    property p_lvl;
        reg_wr && reg_addr == 8'h3e ##1 reg_rd && reg_addr == 8'h3c |=> reg_rdata == 8'h00;
    endproperty
    a_lvl: assert property (p_lvl) else $error("level after flush");
    property p_wm;
        $fell(watermark_irq) |-> $past(host_ev) || $past(host_ev, 2) || $past(host_ev, 3);
    endproperty
    a_wm: assert property (p_wm) else $error("watermark fell alone");
    property p_full;
        $fell(full_irq) |-> $past(host_ev) || $past(host_ev, 2) || $past(host_ev, 3);
    endproperty
    a_full: assert property (p_full) else $error("full fell alone");
    property p_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule // accel_sample_buffer_sva

bind accel_sample_buffer accel_sample_buffer_sva u_accel_sample_buffer_sva (.mclk, .reset,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .watermark_irq, .full_irq);

`default_nettype wire

// [verif/sample_source.sv]
// Front end model handing one sample per request to the buffer
`timescale 1ns/1ns
`default_nettype none

module sample_source (
    // Clock
    input wire mclk,
    // Request from the bench
    input wire fire,
    input wire [47:0] word,
    // Sample port
    output logic sample_valid,
    output logic [47:0] sample_data
);
    initial begin
        sample_valid = 1'b0;
        sample_data = 48'h0;
    end
    // Idle data turns over each cycle so a late capture shows up
    always @(posedge mclk) begin
        sample_valid <= fire;
        sample_data <= fire ? word : ~sample_data;
    end
endmodule // sample_source

`default_nettype wire

// [verif/accel_sample_buffer_bench.sv]
// Self-checking bench for the sample buffer
`timescale 1ns/1ns
`default_nettype none

module accel_sample_buffer_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, read_active = 1'b0, fire = 1'b0;
    logic engine_interrupt = 1'b0, external_trigger_pin = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [47:0] word = 48'h0, s1, s2, s3;
    logic [31:0] seed = 32'hfd81;
    logic [7:0] exp_q[$];
    wire [7:0] reg_rdata;
    wire watermark_irq, full_irq, sample_valid;
    wire [47:0] sample_data;
    int n_errors = 0, tests_run = 0, i;

    always #5 mclk = ~mclk;

    accel_sample_buffer u_accel_sample_buffer (.mclk(mclk), .reset(reset),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .read_active(read_active), .sample_valid(sample_valid),
        .sample_data(sample_data), .engine_interrupt(engine_interrupt),
        .external_trigger_pin(external_trigger_pin), .watermark_irq(watermark_irq),
        .full_irq(full_irq));
    sample_source u_sample_source (.mclk(mclk), .fire(fire), .word(word),
        .sample_valid(sample_valid), .sample_data(sample_data));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One register cycle; calls in a row run back to back
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    // Enable dropped before any change, then buffer emptied
    task automatic cfg(input logic [7:0] c);
        wr(8'h3b, 8'h00);
        wr(8'h3e, 8'h00);
        wr(8'h3b, c);
    endtask
    // Random sample, then enough cycles for its capture of up to seven cycles
    task automatic send(output logic [47:0] v);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (48) seed = lfsr(seed);
        word = {seed[15:0], seed};
        v = word;
        fire = 1'b1;
        @(posedge mclk);
        #1;
        fire = 1'b0;
        repeat (9) @(posedge mclk);
        #1;
    endtask
    task automatic irqs(input logic w, input logic f);
        chk("watermark_irq", {7'h0, w}, {7'h0, watermark_irq});
        chk("full_irq", {7'h0, f}, {7'h0, full_irq});
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Each read answer against the oldest note
    always @(posedge mclk) begin
        if (reg_rd === 1'b1) begin
            #2;
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    initial begin
        repeat (8) @(posedge mclk);
        #1;
        reset = 1'b0;
        rd(8'h3a, 8'h00);
        rd(8'h3b, 8'h00);
        rd(8'h3c, 8'h00);
        rd(8'h3d, 8'h00);
        wr(8'h3b, 8'h7f);
        rd(8'h3b, 8'h63);
        wr(8'h3b, 8'h00);
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'h7f);
        wr(8'h3a, 8'h02);
        send(s1);
        rd(8'h3c, 8'h00);
        wr(8'h3b, 8'hc0);
        read_active = 1'b1;
        send(s1);
        rd(8'h3c, 8'h00);
        read_active = 1'b0;
        $display("test enable and read block done");
        send(s1);
        send(s2);
        irqs(1'b1, 1'b0);
        rd(8'h3c, 8'h0c);
        for (i = 0; i < 6; i++)
            rd(8'h3f, s1[8*i +: 8]);
        rd(8'h3c, 8'h06);
        irqs(1'b0, 1'b0);
        send(s3);
        irqs(1'b1, 1'b0);
        $display("test fifo order done");
        cfg(8'ha0);
        rd(8'h3c, 8'h00);
        for (i = 0; i < 87; i++) begin
            if (i == 0)
                send(s1);
            else
                send(s3);
        end
        irqs(1'b1, 1'b1);
        rd(8'h3c, 8'h02);
        rd(8'h3f, s1[15:8]);
        wr(8'h3e, 8'h5a);
        rd(8'h3c, 8'h00);
        send(s3);
        irqs(1'b0, 1'b0);
        $display("test fifo full done");
        cfg(8'h81);
        send(s1);
        for (i = 0; i < 86; i++) begin
            if (i == 0)
                send(s2);
            else
                send(s3);
        end
        irqs(1'b1, 1'b0);
        rd(8'h3c, 8'h02);
        rd(8'h3f, s2[15:8]);
        cfg(8'hc3);
        send(s1);
        send(s2);
        rd(8'h3f, s2[47:40]);
        rd(8'h3f, s2[39:32]);
        $display("test stream and lifo done");
        cfg(8'h82);
        for (i = 0; i < 4; i++)
            send(s1);
        rd(8'h3d, 8'h00);
        rd(8'h3c, 8'h06);
        external_trigger_pin = 1'b1;
        send(s2);
        external_trigger_pin = 1'b0;
        rd(8'h3d, 8'h80);
        send(s3);
        rd(8'h3c, 8'h09);
        rd(8'h3f, s1[15:8]);
        wr(8'h3e, 8'h00);
        rd(8'h3d, 8'h00);
        engine_interrupt = 1'b1;
        send(s1);
        send(s1);
        rd(8'h3d, 8'h80);
        engine_interrupt = 1'b0;
        send(s1);
        $display("test trigger done");
        if (exp_q.size() != 0)
            n_errors++;
        final_report();
    end
endmodule // accel_sample_buffer_bench

`default_nettype wire
